/* File: hdl/tmr_regs.vh */
// Constants of the 16-bit timer/counter waveform core: register map,
// field positions, mode codes, fixed tops and prescale factors.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMR_OFF_CTRL      8'h00
`define TMR_OFF_COUNT     8'h04
`define TMR_OFF_CMPA      8'h08
`define TMR_OFF_CMPB      8'h0c
`define TMR_OFF_CAPT      8'h10
`define TMR_OFF_FLAG      8'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TMR_CTRL_MODE     3:0
`define TMR_CTRL_ACTA     5:4
`define TMR_CTRL_ACTB     7:6
`define TMR_CTRL_PRE      10:8
`define TMR_CTRL_DIRA     12
`define TMR_CTRL_DIRB     13
`define TMR_CTRL_PORTA    14
`define TMR_CTRL_PORTB    15
`define TMR_CTRL_W        16
`define TMR_CTRL_RST      16'h0000

// ----------------------------------------------------------------------
// Flag register bits
// ----------------------------------------------------------------------
`define TMR_FLG_OVF       0
`define TMR_FLG_CMPA      1
`define TMR_FLG_CMPB      2
`define TMR_FLG_CAPT      3
`define TMR_FLG_W         4

// ----------------------------------------------------------------------
// Wave mode codes
// ----------------------------------------------------------------------
`define TMR_MODE_NORMAL   4'h0
`define TMR_MODE_CTC_A    4'h4
`define TMR_MODE_FPWM8    4'h5
`define TMR_MODE_FPWM9    4'h6
`define TMR_MODE_FPWM10   4'h7
`define TMR_MODE_CTC_CAP  4'hc
`define TMR_MODE_FPWM_CAP 4'he
`define TMR_MODE_FPWM_A   4'hf

// ----------------------------------------------------------------------
// Output action codes
// ----------------------------------------------------------------------
`define TMR_ACT_NONE      2'h0
`define TMR_ACT_TOGGLE    2'h1
`define TMR_ACT_CLEAR     2'h2
`define TMR_ACT_SET       2'h3

// ----------------------------------------------------------------------
// Count limits
// ----------------------------------------------------------------------
`define TMR_MAX           16'hffff
`define TMR_BOTTOM        16'h0000
`define TMR_TOP8          16'h00ff
`define TMR_TOP9          16'h01ff
`define TMR_TOP10         16'h03ff

// ----------------------------------------------------------------------
// Prescale select codes and factors minus one
// ----------------------------------------------------------------------
`define TMR_PRE_STOP      3'h0
`define TMR_PRE_1         3'h1
`define TMR_PRE_8         3'h2
`define TMR_PRE_64        3'h3
`define TMR_PRE_256       3'h4
`define TMR_PRE_1024      3'h5
`define TMR_DIV_1         10'h000
`define TMR_DIV_8         10'h007
`define TMR_DIV_64        10'h03f
`define TMR_DIV_256       10'h0ff
`define TMR_DIV_1024      10'h3ff

`endif

/* File: hdl/tmr_timer16.v */
// 16-bit timer/counter waveform core: Normal, clear-on-match and Fast PWM.
// Assumes an APB master on pclk, and an interrupt controller on the same
// clock that pulses flag_ack for one cycle when it services an interrupt.
//
// Overview of operation
// - Mode selects counting; action selects output behaviour
// - Mode 0 counts up, wraps at 0xFFFF
// - Normal mode sets overflow when count becomes zero
// - Software may write the count any time
// - Clear-on-match top is compare A or capture
// - Clear-on-match top is unbuffered; late top wraps
// - Clear-on-match sets compare A or capture flag
// - Clear-on-match action 1 toggles output A
// - Waveform reaches pin only when direction is output
// - Clear-on-match sets overflow on wrap from max
// - Fast PWM counts single-slope bottom to top
// - Fast PWM top is fixed, capture, or compare A
// - PWM output clears/sets on match, opposite at bottom
// - Fast PWM codes 2 and 3 pick polarity
// - Fast PWM sets overflow at top, plus top flag when top is capture or compare A
// - Fixed top masks compare writes to resolution
// - Fast PWM capture top is unbuffered
// - Fast PWM compare A buffered, loaded at top
// - Compare zero gives spike; compare top constant
// - Fast PWM toggle only on output A in mode 0xF
// - Fast PWM sets compare flag on match
// - Compare flag sets in tick after match
// - Flags clear on service or writing one
// - Waveform registers reset to zero
`timescale 1ns/10ps
`include "tmr_regs.vh"

module tmr_timer16
#(
   parameter FPWM_CODE2_INVERTED = 1
)
(
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   flag_ack,
   flags,
   wave_pin_a,
   wave_oe_a,
   wave_pin_b,
   wave_oe_b
);
   input  wire        pclk;
   input  wire        presetn;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [7:0]  paddr;
   input  wire [31:0] pwdata;
   output reg  [31:0] prdata;
   output reg         pready;
   output reg         pslverr;
   input  wire [3:0]  flag_ack;
   output reg  [3:0]  flags;
   output reg         wave_pin_a;
   output reg         wave_oe_a;
   output reg         wave_pin_b;
   output reg         wave_oe_b;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function is_fast;
      input [3:0] m;
      begin
         is_fast = (m == `TMR_MODE_FPWM8) || (m == `TMR_MODE_FPWM9) ||
                   (m == `TMR_MODE_FPWM10) || (m == `TMR_MODE_FPWM_CAP) ||
                   (m == `TMR_MODE_FPWM_A);
      end
   endfunction

   // Mask for compare writes; fixed tops drop the bits above resolution
   function [15:0] cmp_mask;
      input [3:0] m;
      begin
         case (m)
            `TMR_MODE_FPWM8:  cmp_mask = `TMR_TOP8;
            `TMR_MODE_FPWM9:  cmp_mask = `TMR_TOP9;
            `TMR_MODE_FPWM10: cmp_mask = `TMR_TOP10;
            default:          cmp_mask = `TMR_MAX;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg [15:0] ctrl_a_reg_r;
   reg [15:0] count_value_r;
   reg [15:0] cmpa_buf_r;
   reg [15:0] compare_a_value_r;
   reg [15:0] compare_b_value_r;
   reg [15:0] capture_value_r;
   reg [3:0]  flag_reg_r;
   reg        wave_out_a_r;
   reg        wave_out_b_r;
   reg [9:0]  pre_cnt_r;

   wire [3:0] wave_mode_sel    = ctrl_a_reg_r[`TMR_CTRL_MODE];
   wire [1:0] out_action_a_sel = ctrl_a_reg_r[`TMR_CTRL_ACTA];
   wire [1:0] out_action_b_sel = ctrl_a_reg_r[`TMR_CTRL_ACTB];
   wire [2:0] pre_sel          = ctrl_a_reg_r[`TMR_CTRL_PRE];

   // -------------------------------------------------------------------
   // APB access
   // -------------------------------------------------------------------
   // Access completes in the first access cycle: pready rises there
   wire acc    = psel & penable & pready;
   wire wr     = acc & pwrite;
   wire mapped = (paddr == `TMR_OFF_CTRL) || (paddr == `TMR_OFF_COUNT) ||
                 (paddr == `TMR_OFF_CMPA) || (paddr == `TMR_OFF_CMPB) ||
                 (paddr == `TMR_OFF_CAPT) || (paddr == `TMR_OFF_FLAG);
   wire wr_ctrl  = wr & (paddr == `TMR_OFF_CTRL);
   wire wr_count = wr & (paddr == `TMR_OFF_COUNT);
   wire wr_cmpa  = wr & (paddr == `TMR_OFF_CMPA);
   wire wr_cmpb  = wr & (paddr == `TMR_OFF_CMPB);
   wire wr_capt  = wr & (paddr == `TMR_OFF_CAPT);
   wire wr_flag  = wr & (paddr == `TMR_OFF_FLAG);

   reg [31:0] rd_mux;
   always @*
   begin
      rd_mux = 32'h00000000;
      case (paddr)
         `TMR_OFF_CTRL:  rd_mux[15:0] = ctrl_a_reg_r;
         `TMR_OFF_COUNT: rd_mux[15:0] = count_value_r;
         `TMR_OFF_CMPA:  rd_mux[15:0] = cmpa_buf_r;
         `TMR_OFF_CMPB:  rd_mux[15:0] = compare_b_value_r;
         `TMR_OFF_CAPT:  rd_mux[15:0] = capture_value_r;
         `TMR_OFF_FLAG:  rd_mux[3:0]  = flag_reg_r;
         default:        rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux;
      end
   end

   // -------------------------------------------------------------------
   // Prescaler
   // -------------------------------------------------------------------
   reg [9:0] div_lim;
   always @*
   begin
      case (pre_sel)
         `TMR_PRE_1:    div_lim = `TMR_DIV_1;
         `TMR_PRE_8:    div_lim = `TMR_DIV_8;
         `TMR_PRE_64:   div_lim = `TMR_DIV_64;
         `TMR_PRE_256:  div_lim = `TMR_DIV_256;
         `TMR_PRE_1024: div_lim = `TMR_DIV_1024;
         default:       div_lim = `TMR_DIV_1;
      endcase
   end

   wire run  = (pre_sel != `TMR_PRE_STOP);
   wire tick = run & (pre_cnt_r >= div_lim);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_cnt_r <= 10'h000;
      else if (!run || tick)
         pre_cnt_r <= 10'h000;
      else
         pre_cnt_r <= pre_cnt_r + 10'h001;
   end

   // -------------------------------------------------------------------
   // Counting sequence
   // -------------------------------------------------------------------
   wire fast = is_fast(wave_mode_sel);
   wire clear_on_match_mode  = (wave_mode_sel == `TMR_MODE_CTC_A) ||
               (wave_mode_sel == `TMR_MODE_CTC_CAP);

   reg [15:0] top;
   always @*
   begin
      case (wave_mode_sel)
         `TMR_MODE_CTC_A:    top = compare_a_value_r;
         `TMR_MODE_CTC_CAP:  top = capture_value_r;
         `TMR_MODE_FPWM8:    top = `TMR_TOP8;
         `TMR_MODE_FPWM9:    top = `TMR_TOP9;
         `TMR_MODE_FPWM10:   top = `TMR_TOP10;
         `TMR_MODE_FPWM_CAP: top = capture_value_r;
         `TMR_MODE_FPWM_A:   top = compare_a_value_r;
         default:            top = `TMR_MAX;
      endcase
   end

   // Top is compared live, so a top written below the count wraps first
   wire at_top  = (count_value_r == top);
   wire at_max  = (count_value_r == `TMR_MAX);
   wire restart = (clear_on_match_mode | fast) & at_top;
   wire match_a = (count_value_r == compare_a_value_r);
   wire match_b = (count_value_r == compare_b_value_r);
   wire top_cap = (wave_mode_sel == `TMR_MODE_CTC_CAP) ||
                  (wave_mode_sel == `TMR_MODE_FPWM_CAP);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_value_r <= `TMR_BOTTOM;
      else if (wr_count)
         count_value_r <= pwdata[15:0];
      else if (tick && restart)
         count_value_r <= `TMR_BOTTOM;
      else if (tick)
         count_value_r <= count_value_r + 16'h0001;
   end

   // -------------------------------------------------------------------
   // Compare and capture registers
   // -------------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_a_reg_r      <= `TMR_CTRL_RST;
         cmpa_buf_r        <= `TMR_BOTTOM;
         compare_a_value_r <= `TMR_BOTTOM;
         compare_b_value_r <= `TMR_BOTTOM;
         capture_value_r   <= `TMR_BOTTOM;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_a_reg_r <= pwdata[`TMR_CTRL_W-1:0];
         if (wr_cmpa)
            cmpa_buf_r <= pwdata[15:0] & cmp_mask(wave_mode_sel);
         if (wr_cmpa && !fast)
            compare_a_value_r <= pwdata[15:0];
         else if (fast && tick && at_top)
            compare_a_value_r <= cmpa_buf_r;
         if (wr_cmpb)
            compare_b_value_r <= pwdata[15:0] & cmp_mask(wave_mode_sel);
         if (wr_capt)
            capture_value_r <= pwdata[15:0];
      end
   end

   // -------------------------------------------------------------------
   // Flags
   // -------------------------------------------------------------------
   // Overflow: wrap from max outside PWM, reaching top in Fast PWM
   wire set_ovf  = tick & (fast ? at_top : at_max);
   // Compare flags on the tick edge closing the match tick
   wire set_cmpa = tick & match_a;
   wire set_cmpb = tick & match_b;
   wire set_capt = tick & top_cap & at_top;
   wire [3:0] flag_set = {set_capt, set_cmpb, set_cmpa, set_ovf};
   wire [3:0] flag_clr = flag_ack | (wr_flag ? pwdata[3:0] : 4'h0);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_reg_r <= 4'h0;
      else
         flag_reg_r <= (flag_reg_r & ~flag_clr) | flag_set;
   end

   // -------------------------------------------------------------------
   // Waveform generation
   // -------------------------------------------------------------------
   // Polarity per Fast PWM code; parameter allows the opposite reading
   wire code2_inv = (FPWM_CODE2_INVERTED != 0);

   function wave_next;
      input       cur;
      input [1:0] act;
      input       match;
      input       fastm;
      input       topm;
      input       tgl_ok;
      input       inv2;
      reg         inv;
      begin
         wave_next = cur;
         inv       = (act == `TMR_ACT_CLEAR) ? inv2 : ~inv2;
         if (!fastm)
         begin
            if (match)
            begin
               case (act)
                  `TMR_ACT_TOGGLE: wave_next = ~cur;
                  `TMR_ACT_CLEAR:  wave_next = 1'b0;
                  `TMR_ACT_SET:    wave_next = 1'b1;
                  default:         wave_next = cur;
               endcase
            end
         end
         else if (act == `TMR_ACT_TOGGLE)
         begin
            if (match && tgl_ok)
               wave_next = ~cur;
         end
         else if (act != `TMR_ACT_NONE)
         begin
            // Bottom action wins so compare equal to top holds a level
            if (topm)
               wave_next = inv ? 1'b0 : 1'b1;
            else if (match)
               wave_next = inv ? 1'b1 : 1'b0;
         end
      end
   endfunction

   wire tgl_a = (wave_mode_sel == `TMR_MODE_FPWM_A);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wave_out_a_r <= 1'b0;
         wave_out_b_r <= 1'b0;
      end
      else if (tick)
      begin
         wave_out_a_r <= wave_next(wave_out_a_r, out_action_a_sel, match_a,
                                   fast, at_top, tgl_a, code2_inv);
         wave_out_b_r <= wave_next(wave_out_b_r, out_action_b_sel, match_b,
                                   fast, at_top, 1'b0, code2_inv);
      end
   end

   // -------------------------------------------------------------------
   // Pin override and flag outputs
   // -------------------------------------------------------------------
   // Action 0 leaves the pin to its port bit; direction always rules
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wave_pin_a <= 1'b0;
         wave_oe_a  <= 1'b0;
         wave_pin_b <= 1'b0;
         wave_oe_b  <= 1'b0;
         flags      <= 4'h0;
      end
      else
      begin
         wave_pin_a <= (out_action_a_sel != `TMR_ACT_NONE) ? wave_out_a_r
                       : ctrl_a_reg_r[`TMR_CTRL_PORTA];
         wave_oe_a  <= ctrl_a_reg_r[`TMR_CTRL_DIRA];
         wave_pin_b <= (out_action_b_sel != `TMR_ACT_NONE) ? wave_out_b_r
                       : ctrl_a_reg_r[`TMR_CTRL_PORTB];
         wave_oe_b  <= ctrl_a_reg_r[`TMR_CTRL_DIRB];
         flags      <= flag_reg_r;
      end
   end

endmodule

/* File: verif/tmr_tb.sv */
// Self-checking bench for the 16-bit timer core over APB.
// Assumes the design's register header is on the include path.
`timescale 1ns/10ps
`include "tmr_regs.vh"

module tb;
   reg         pclk;
   reg         presetn;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata;
   reg  [3:0]  flag_ack;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [3:0]  flags;
   wire        wave_pin_a;
   wire        wave_oe_a;
   wire        wave_pin_b;
   wire        wave_oe_b;
   integer     n_errors;
   integer     num_checks;
   integer     i;
   integer     k;
   reg  [31:0] rd;
   reg         er;
   reg  [56:0] rows [0:5];

   tmr_timer16 tmr_timer16_i
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .flag_ack   (flag_ack),
      .flags      (flags),
      .wave_pin_a (wave_pin_a),
      .wave_oe_a  (wave_oe_a),
      .wave_pin_b (wave_pin_b),
      .wave_oe_b  (wave_oe_b)
   );

   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task give_verdict;
   begin
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   task check(input ok, input [191:0] msg);
   begin
      num_checks = num_checks + 1;
      if (ok !== 1'b1)
      begin
         n_errors = n_errors + 1;
         $display("MISMATCH at %0t: %0s", $time, msg);
      end
   end
   endtask

   // Holds the request until pready is seen high at a rising edge
   task apb(input [7:0] a, input w, input [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 16)
      begin
         k = k + 1;
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 16)
      begin
         check(1'b0, "bus timeout");
         give_verdict;
      end
   end
   endtask

   task rdchk(input [7:0] a, input [15:0] e);
   begin
      apb(a, 1'b0, 32'h0);
      check(rd === {16'h0, e} && er === 1'b0, "read data");
   end
   endtask

   // Spacing of toggles on output A; the first changes are skipped
   // because the buffered top may still hold the previous value
   task gap_chk(input integer g);
      integer t;
      integer last;
      integer nch;
      reg     prev;
   begin
      last = 0;
      nch = 0;
      for (t = 0; t < 80; t = t + 1)
      begin
         prev = wave_pin_a;
         @(posedge pclk);
         #1;
         if (wave_pin_a !== prev)
         begin
            nch = nch + 1;
            if (nch > 3)
               check(t - last == g, "toggle spacing");
            last = t;
         end
      end
      check(nch > 10, "toggle count");
   end
   endtask

   task duty_chk(input integer hi);
      integer t;
      integer nh;
   begin
      nh = 0;
      repeat (20) @(posedge pclk);
      for (t = 0; t < 40; t = t + 1)
      begin
         @(posedge pclk);
         #1;
         if (wave_pin_b === 1'b1)
            nh = nh + 1;
      end
      check(nh == hi, "pwm duty");
   end
   endtask

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      n_errors = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      flag_ack = 4'h0;
      // Address, write data, expected read, expected error
      rows[0] = {`TMR_OFF_COUNT, 32'h0000_1234, 16'h1234, 1'b0};
      rows[1] = {`TMR_OFF_CMPA, 32'h0000_abcd, 16'habcd, 1'b0};
      rows[2] = {`TMR_OFF_CMPB, 32'hffff_5555, 16'h5555, 1'b0};
      rows[3] = {`TMR_OFF_CAPT, 32'h0000_0003, 16'h0003, 1'b0};
      rows[4] = {8'h18, 32'h0000_0001, 16'h0000, 1'b1};
      rows[5] = {`TMR_OFF_CTRL, 32'h0000_3000, 16'h3000, 1'b0};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
         rdchk(8'(4 * i), 16'h0000);
      for (i = 0; i < 6; i = i + 1)
      begin
         apb(rows[i][56:49], 1'b1, rows[i][48:17]);
         apb(rows[i][56:49], 1'b0, 32'h0);
         check(rd === {16'h0, rows[i][16:1]} && er === rows[i][0], "register");
      end
      apb(`TMR_OFF_COUNT, 1'b1, 32'hfffd);
      apb(`TMR_OFF_CTRL, 1'b1, 32'h0100);
      k = 0;
      while (flags[0] !== 1'b1 && k < 10)
      begin
         @(posedge pclk);
         k = k + 1;
      end
      check(k == 5, "overflow timing");
      apb(`TMR_OFF_COUNT, 1'b0, 32'h0);
      check(rd[31:4] === 28'h0, "wrap to zero");
      apb(`TMR_OFF_FLAG, 1'b1, 32'h1);
      rdchk(`TMR_OFF_FLAG, 16'h0000);
      apb(`TMR_OFF_CTRL, 1'b1, 32'h3000);
      apb(`TMR_OFF_COUNT, 1'b1, 32'h0);
      apb(`TMR_OFF_CMPA, 1'b1, 32'h2);
      apb(`TMR_OFF_FLAG, 1'b1, 32'hf);
      apb(`TMR_OFF_CTRL, 1'b1, 32'h3114);
      gap_chk(3);
      check(flags[1] === 1'b1, "top flag");
      // New top goes to the buffer while stopped in the toggling mode
      apb(`TMR_OFF_CTRL, 1'b1, 32'h300f);
      apb(`TMR_OFF_CMPA, 1'b1, 32'h4);
      apb(`TMR_OFF_COUNT, 1'b1, 32'h0);
      apb(`TMR_OFF_CTRL, 1'b1, 32'h311f);
      gap_chk(5);
      for (i = 0; i < 3; i = i + 1)
      begin
         apb(`TMR_OFF_CTRL, 1'b1, 32'(5 + i));
         apb(`TMR_OFF_CMPB, 1'b1, 32'hffff);
         rdchk(`TMR_OFF_CMPB, 16'((32'h100 << i) - 1));
      end
      apb(`TMR_OFF_CTRL, 1'b1, 32'h000e);
      apb(`TMR_OFF_CMPB, 1'b1, 32'h3);
      apb(`TMR_OFF_CAPT, 1'b1, 32'h9);
      apb(`TMR_OFF_COUNT, 1'b1, 32'h0);
      apb(`TMR_OFF_FLAG, 1'b1, 32'hf);
      for (i = 2; i < 4; i = i + 1)
      begin
         apb(`TMR_OFF_CTRL, 1'b1, 32'h210e | (i << 6));
         duty_chk(i == 3 ? 16 : 24);
      end
      apb(`TMR_OFF_CTRL, 1'b1, 32'h000e);
      repeat (3) @(posedge pclk);
      check(flags === 4'hf, "flags at top");
      flag_ack <= 4'h8;
      @(posedge pclk);
      flag_ack <= 4'h0;
      repeat (3) @(posedge pclk);
      check(flags === 4'h7, "service clear");
      rdchk(`TMR_OFF_FLAG, 16'h0007);
      // Capture top at /8: four ticks of eight cycles each before the flags
      apb(`TMR_OFF_CAPT, 1'b1, 32'h3);
      apb(`TMR_OFF_COUNT, 1'b1, 32'h0);
      apb(`TMR_OFF_FLAG, 1'b1, 32'hf);
      apb(`TMR_OFF_CTRL, 1'b1, 32'h020c);
      k = 0;
      while (flags[3] !== 1'b1 && k < 60)
      begin
         @(posedge pclk);
         k = k + 1;
      end
      check(k == 34, "capture top timing");
      check(flags === 4'hc, "capture top flags");
      apb(`TMR_OFF_CTRL, 1'b1, 32'h31ce);
      repeat (5) @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      check({flags, wave_pin_b, wave_oe_a, wave_oe_b} === 7'h0, "reset outputs");
      give_verdict;
   end
endmodule

/* File: verif/tmr_timer16_chk.sv */
// Checker for the 16-bit timer core, watching only its ports.
// Assumes the design's register header is on the include path.
`timescale 1ns/10ps
`include "tmr_regs.vh"

module tmr_timer16_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  flag_ack,
   input wire logic [3:0]  flags,
   input wire logic        wave_pin_a,
   input wire logic        wave_oe_a,
   input wire logic        wave_pin_b,
   input wire logic        wave_oe_b
);
   // -------------------------------------------------------------------
   // Shadow of the control register, rebuilt from completed writes
   // -------------------------------------------------------------------
   reg  [15:0] ctrl_sh_r;
   wire        wr_done = psel && penable && pready && pwrite;
   wire        stopped = (ctrl_sh_r[`TMR_CTRL_PRE] == `TMR_PRE_STOP);
   wire [3:0]  clr     = flag_ack | ((wr_done && paddr == `TMR_OFF_FLAG) ? pwdata[3:0] : 4'h0);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_sh_r <= 16'h0000;
      else if (wr_done && paddr == `TMR_OFF_CTRL)
         ctrl_sh_r <= pwdata[15:0];
   end

   // -------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rdy;
      (psel && !penable) |=> pready;
   endproperty
   property p_rdy_one;
      pready |=> !pready;
   endproperty
   property p_err;
      (pready && paddr[1:0] == 2'b00) |-> (pslverr == (paddr > `TMR_OFF_FLAG));
   endproperty
   property p_rd_zero;
      (pready && !pwrite && pslverr) |-> (prdata == 32'h0);
   endproperty
   property p_oe;
      {wave_oe_b, wave_oe_a} ==
         $past({ctrl_sh_r[`TMR_CTRL_DIRB], ctrl_sh_r[`TMR_CTRL_DIRA]});
   endproperty
   property p_pin_port;
      ($past(ctrl_sh_r[`TMR_CTRL_ACTA]) == `TMR_ACT_NONE)
         |-> (wave_pin_a == $past(ctrl_sh_r[`TMR_CTRL_PORTA]));
   endproperty
   property p_rst;
      $rose(presetn) |-> (flags == 4'h0 && !wave_pin_a && !wave_pin_b && !pready);
   endproperty
   // Clears are only judged while stopped: a set in the same tick wins
   property p_clr;
      (stopped[*3] ##0 (clr != 4'h0)) |-> ##2 ((flags & $past(clr, 2)) == 4'h0);
   endproperty
   property p_stop;
      stopped[*4] |-> ((flags & ~$past(flags)) == 4'h0);
   endproperty

   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error response wrong");
   a_rd_zero: assert property (p_rd_zero) else $error("refused read not zero");
   a_oe: assert property (p_oe) else $error("drive enable differs from direction");
   a_pin_port: assert property (p_pin_port) else $error("pin not port bit");
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   a_clr: assert property (p_clr) else $error("flag not cleared");
   a_stop: assert property (p_stop) else $error("flag set while stopped");

   c_err: cover property (pready && pslverr);
   c_ack: cover property (flag_ack != 4'h0);
   c_run: cover property (!stopped && wave_oe_a);
endmodule

bind tmr_timer16 tmr_timer16_chk tmr_timer16_chk_i
(
   .pclk       (pclk),
   .presetn    (presetn),
   .psel       (psel),
   .penable    (penable),
   .pwrite     (pwrite),
   .paddr      (paddr),
   .pwdata     (pwdata),
   .prdata     (prdata),
   .pready     (pready),
   .pslverr    (pslverr),
   .flag_ack   (flag_ack),
   .flags      (flags),
   .wave_pin_a (wave_pin_a),
   .wave_oe_a  (wave_oe_a),
   .wave_pin_b (wave_pin_b),
   .wave_oe_b  (wave_oe_b)
);
